//--- hw/gpio_function_and_bit_ops.sv
// Function select, bit clear/invert and very-high-speed register block
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_function_and_bit_ops
    import gpio_fbo_pkg::*;
#(
    parameter bit HAS_HIGH_FUNCS = 1'b1
)
(
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_b,
    // AXI4-Lite write address
    input  wire logic                i_awvalid,
    output logic                     o_awready,
    input  wire logic [7:0]          i_awaddr,
    // AXI4-Lite write data
    input  wire logic                i_wvalid,
    output logic                     o_wready,
    input  wire logic [31:0]         i_wdata,
    input  wire logic [3:0]          i_wstrb,
    // AXI4-Lite write response
    output logic                     o_bvalid,
    input  wire logic                i_bready,
    output logic [1:0]               o_bresp,
    // AXI4-Lite read address
    input  wire logic                i_arvalid,
    output logic                     o_arready,
    input  wire logic [7:0]          i_araddr,
    // AXI4-Lite read data
    output logic                     o_rvalid,
    input  wire logic                i_rready,
    output logic [31:0]              o_rdata,
    output logic [1:0]               o_rresp,
    // Pin side
    output logic [PIN_COUNT-1:0]     o_output_level,
    output logic [8*8-1:0]           o_high_pin_route,
    output logic [PIN_COUNT-1:0]     o_very_high_speed
);
    // **************************************************************
    // Register storage
    // **************************************************************
    logic [31:0]               pin_function_select_high;
    logic [PIN_COUNT-1:0]      very_high_speed_enable;
    logic [PIN_COUNT-1:0]      output_level;
    logic [2*PIN_COUNT-1:0]    speed_field;
    logic                      aw_held;
    logic                      w_held;
    logic [7:0]                aw_addr;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    wr_state_t                 wr_state;
    logic                      do_write;
    logic [31:0]               lane_mask;
    logic                      wr_mapped;
    logic                      wr_size_bad;

    // **************************************************************
    // Write channel
    // **************************************************************
    // Address and data may arrive in either order; each is latched once
    assign o_awready = (wr_state == WR_IDLE) && !aw_held;
    assign o_wready  = (wr_state == WR_IDLE) && !w_held;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (o_awready && i_awvalid)
        begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            w_held <= 1'b0;
            w_data <= REG_RESET;
            w_strb <= 4'h0;
        end
        else if (o_wready && i_wvalid)
        begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    // Commit happens the cycle both halves are held
    assign do_write = (wr_state == WR_IDLE) && aw_held && w_held;

    // Byte lanes expand to a bit mask for lane-accurate actions
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{w_strb[lane]}};
        end
    endgenerate

    always_comb
    begin
        wr_mapped = (aw_addr == FUNC_SEL_HIGH_OFS) ||
                    (aw_addr == BIT_CLEAR_OFS) ||
                    (aw_addr == BIT_INVERT_OFS) ||
                    (aw_addr == VHS_ENABLE_OFS) ||
                    (aw_addr == OUTPUT_LEVEL_OFS) ||
                    (aw_addr == SPEED_FIELD_OFS);
        // Partial word on the speed enable register is refused whole
        wr_size_bad = (aw_addr == VHS_ENABLE_OFS) && (w_strb != 4'hf);
    end

    // Response state: idle, then answer until taken
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            wr_state <= WR_IDLE;
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end
        else
        begin
            case (wr_state)
                WR_IDLE:
                    if (do_write)
                    begin
                        wr_state <= WR_RESP;
                        o_bvalid <= 1'b1;
                        o_bresp  <= (wr_mapped && !wr_size_bad) ?
                                    RESP_OKAY : RESP_SLVERR;
                    end
                WR_RESP:
                    if (i_bready)
                    begin
                        wr_state <= WR_IDLE;
                        o_bvalid <= 1'b0;
                    end
                default:
                begin
                    wr_state <= WR_IDLE;
                    o_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // **************************************************************
    // Register updates
    // **************************************************************
    // Function codes: stored as written, lane by lane
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            pin_function_select_high <= REG_RESET;
        else if (do_write && aw_addr == FUNC_SEL_HIGH_OFS)
            pin_function_select_high <=
                (w_data & lane_mask) |
                (pin_function_select_high & ~lane_mask);
    end

    // Speed enable: only a full word is accepted
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            very_high_speed_enable <= '0;
        else if (do_write && aw_addr == VHS_ENABLE_OFS && !wr_size_bad)
            very_high_speed_enable <= w_data[PIN_COUNT-1:0];
    end

    // Speed fields, a small holding copy so the qualification is visible
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            speed_field <= '0;
        else if (do_write && aw_addr == SPEED_FIELD_OFS)
            speed_field <= (w_data & lane_mask) | (speed_field & ~lane_mask);
    end

    // Output latch: direct write, clear action, invert action.
    // Clear and invert are one-shot; nothing of them is stored.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            output_level <= '0;
        else if (do_write && aw_addr == OUTPUT_LEVEL_OFS)
            output_level <= (w_data[PIN_COUNT-1:0] & lane_mask[PIN_COUNT-1:0])
                            | (output_level & ~lane_mask[PIN_COUNT-1:0]);
        else if (do_write && aw_addr == BIT_CLEAR_OFS)
            output_level <= output_level &
                ~(w_data[PIN_COUNT-1:0] & lane_mask[PIN_COUNT-1:0]);
        else if (do_write && aw_addr == BIT_INVERT_OFS)
            output_level <= output_level ^
                (w_data[PIN_COUNT-1:0] & lane_mask[PIN_COUNT-1:0]);
    end

    // **************************************************************
    // Pin side outputs
    // **************************************************************
    assign o_output_level = output_level;

    genvar pin;
    generate
        for (pin = 0; pin < PIN_COUNT; pin++)
        begin : g_speed
            // Enable means nothing unless the field is at its maximum
            assign o_very_high_speed[pin] = very_high_speed_enable[pin] &&
                (speed_field[2*pin +: 2] == SPEED_MAX_FIELD);
        end
        for (pin = 0; pin < 8; pin++)
        begin : g_route
            func_route_decode #(
                .HAS_HIGH_FUNCS (HAS_HIGH_FUNCS)
            ) u_dec (
                .i_code  (pin_function_select_high[pin*CODE_W +: CODE_W]),
                .o_route (o_high_pin_route[pin*8 +: 8])
            );
        end
    endgenerate

    // **************************************************************
    // Read channel
    // **************************************************************
    // One read at a time; answer registered the cycle after the address
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_rvalid <= 1'b0;
            o_rdata  <= REG_RESET;
            o_rresp  <= RESP_OKAY;
        end
        else if (o_arready && i_arvalid)
        begin
            o_rvalid <= 1'b1;
            o_rresp  <= RESP_OKAY;
            case (i_araddr)
                FUNC_SEL_HIGH_OFS: o_rdata <= pin_function_select_high;
                BIT_CLEAR_OFS:     o_rdata <= REG_RESET;
                BIT_INVERT_OFS:    o_rdata <= REG_RESET;
                VHS_ENABLE_OFS:    o_rdata <= {16'h0000, very_high_speed_enable};
                OUTPUT_LEVEL_OFS:  o_rdata <= {16'h0000, output_level};
                SPEED_FIELD_OFS:   o_rdata <= speed_field;
                default:
                begin
                    o_rdata <= REG_RESET;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (i_rready)
            o_rvalid <= 1'b0;
    end

    // **************************************************************
    // Checks
    // **************************************************************
    // Clear takes low every set data bit in the lanes that the strobe enables
    clear_effect_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (do_write && aw_addr == BIT_CLEAR_OFS) |=>
        ((output_level & $past(w_data[PIN_COUNT-1:0]
            & lane_mask[PIN_COUNT-1:0])) == '0))
        else $error("clear left a bit high");

    invert_effect_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (do_write && aw_addr == BIT_INVERT_OFS) |=>
        (output_level == ($past(output_level) ^ ($past(w_data[PIN_COUNT-1:0])
            & $past(lane_mask[PIN_COUNT-1:0])))))
        else $error("invert result wrong");

    speed_qual_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_very_high_speed[0] |-> (speed_field[1:0] == SPEED_MAX_FIELD))
        else $error("very high speed without max field");

    sel_update_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (do_write && aw_addr == FUNC_SEL_HIGH_OFS && w_strb == 4'hf) |=>
        (pin_function_select_high == $past(w_data)))
        else $error("function select not updated");

    route_zero_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (pin_function_select_high[3:0] == 4'h0) |->
        (o_high_pin_route[7:0] == 8'h01))
        else $error("code zero does not route function zero");

    // Codes 4 to 7 reach the upper functions only where the port has them
    route_high_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (pin_function_select_high[3:2] == 2'b01) |->
        ((o_high_pin_route[7:4] != 4'h0) == HAS_HIGH_FUNCS))
        else $error("upper function routing wrong");

    vhs_partial_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (do_write && aw_addr == VHS_ENABLE_OFS && w_strb != 4'hf) |=>
        ($stable(very_high_speed_enable) && o_bresp == RESP_SLVERR))
        else $error("partial speed write accepted");

    wo_read_zero_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (o_arready && i_arvalid && (i_araddr == BIT_CLEAR_OFS ||
            i_araddr == BIT_INVERT_OFS)) |=> (o_rvalid && o_rdata == REG_RESET))
        else $error("write-only register read nonzero");

    reset_zero_a: assert property (
        @(posedge i_core_clk)
        !i_rst_b |=> (pin_function_select_high == REG_RESET &&
            very_high_speed_enable == '0))
        else $error("registers not zero after reset");

    // Action bits leave nothing behind: the pin holds between writes
    level_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !do_write |=> $stable(o_output_level))
        else $error("pin level moved without a write");
endmodule
`default_nettype wire

//--- common/gpio_fbo_pkg.sv
// Constants for the port function select and bit action block
// **************************************************************
// **************************************************************
package gpio_fbo_pkg;
    localparam logic [7:0]  FUNC_SEL_HIGH_OFS = 8'h24;
    localparam logic [7:0]  BIT_CLEAR_OFS     = 8'h28;
    localparam logic [7:0]  BIT_INVERT_OFS    = 8'h2c;
    localparam logic [7:0]  VHS_ENABLE_OFS    = 8'h3c;
    localparam logic [7:0]  OUTPUT_LEVEL_OFS  = 8'h14;
    localparam logic [7:0]  SPEED_FIELD_OFS   = 8'h40;
    localparam logic [31:0] REG_RESET         = 32'h0000_0000;
    localparam logic [3:0]  FUNC_LAST_COMMON  = 4'h3;
    localparam logic [3:0]  FUNC_LAST_AB      = 4'h7;
    localparam logic [1:0]  SPEED_MAX_FIELD   = 2'h3;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
    localparam int          PIN_COUNT         = 16;
    localparam int          CODE_W            = 4;
    localparam int          HIGH_PIN_BASE     = 8;
    typedef enum logic [2:0]
    {
        WR_IDLE = 3'h1,
        WR_RESP = 3'h2,
        WR_HOLD = 3'h4
    } wr_state_t;
endpackage

//--- hw/func_route_decode.sv
// Decoder from a 4-bit function code to a one-hot route select
`timescale 1ns/1ps
`default_nettype none
module func_route_decode
    import gpio_fbo_pkg::*;
#(
    parameter bit HAS_HIGH_FUNCS = 1'b1
)
(
    // Code in
    input  wire logic [CODE_W-1:0] i_code,
    // Route select out
    output logic [7:0]             o_route
);
    // Codes above the port's range and reserved codes route nothing
    always_comb
    begin
        o_route = 8'h00;
        if (i_code <= FUNC_LAST_COMMON)
            o_route[i_code[2:0]] = 1'b1;
        else if (HAS_HIGH_FUNCS && i_code <= FUNC_LAST_AB)
            o_route[i_code[2:0]] = 1'b1;
    end
endmodule
`default_nettype wire

//--- bench/pin_far_side.sv
// Far-side model of the pads fed by the port
`timescale 1ns/1ps
`default_nettype none
module pin_far_side
(
    // From the port
    input  wire logic [15:0] i_output_level,
    input  wire logic [15:0] i_very_high_speed,
    // Pad view
    output logic [15:0]      o_pad_level,
    output logic [15:0]      o_pad_fast
);
    // Pads follow the latch; drive strength and slew are not modelled
    assign o_pad_level = i_output_level;
    assign o_pad_fast  = i_very_high_speed;
endmodule
`default_nettype wire

//--- bench/test_gpio_function_and_bit_ops.sv
// Self-checking bench for the function select and bit action block
`timescale 1ns/1ps
`default_nettype none
module test_gpio_function_and_bit_ops;
    import gpio_fbo_pkg::*;
    // Bus drive, observed outputs and bench model state
    logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, m_sel, m_spd, d, v;
    logic [3:0]  wstrb, s4;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] level, vhs, pad_level, pad_fast, m_level, m_vhs, mk;
    logic [63:0] route;
    logic [7:0]  regs [6] = '{FUNC_SEL_HIGH_OFS, BIT_CLEAR_OFS,
        BIT_INVERT_OFS, VHS_ENABLE_OFS, OUTPUT_LEVEL_OFS, SPEED_FIELD_OFS};
    int          errors, num_checks, op, p;

    gpio_function_and_bit_ops gpio_function_and_bit_ops_inst
    (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp), .o_output_level(level),
        .o_high_pin_route(route), .o_very_high_speed(vhs)
    );
    pin_far_side pin_far_side_inst
    (
        .i_output_level(level), .i_very_high_speed(vhs),
        .o_pad_level(pad_level), .o_pad_fast(pad_fast)
    );

    // 10 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************************************
    // Expectation functions and bus tasks
    // ****************************************************************
    // Byte lanes enabled by a write strobe
    function automatic logic [31:0] lanes(input logic [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    // Reserved codes (top bit set) route nothing
    function automatic logic [63:0] exp_route(input logic [31:0] sel);
        exp_route = 64'h0;
        for (int q = 0; q < 8; q++)
            if (sel[4*q+3] === 1'b0)
                exp_route[8*q +: 8] = 8'h01 << sel[4*q +: 3];
    endfunction
    // A pin is fast only with its enable and a full speed field
    function automatic logic [15:0] exp_vhs(input logic [15:0] en,
                                            input logic [31:0] f);
        for (int y = 0; y < 16; y++)
            exp_vhs[y] = en[y] & (f[2*y +: 2] == 2'h3);
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_route(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each released once taken
    task automatic bus_write(input logic [7:0] a, input logic [31:0] x,
                             input logic [3:0] s);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= x;
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge clk);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_read(input logic [7:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        rst_b = 1'b0;
        m_level = 16'h0;
        v = $urandom(32'hd87d5a47);
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        check_route(route, exp_route(REG_RESET));
        check_word({level, vhs}, 32'h0);
        foreach (regs[i])
        begin
            bus_read(regs[i]);
            check_word(d, REG_RESET);
        end
        // Legal codes 0 to 7 twice each; reserved codes are never written
        for (int c = 0; c < 16; c++)
        begin
            p = $urandom_range(7);
            v = $urandom & 32'h7777_7777;
            v[4*p +: 4] = 4'(c % 8);
            bus_write(FUNC_SEL_HIGH_OFS, v, 4'hf);
            m_sel = v;
            check_word({30'h0, rsp}, {30'h0, RESP_OKAY});
            check_route(route, exp_route(m_sel));
            bus_read(FUNC_SEL_HIGH_OFS);
            check_word(d, m_sel);
        end
        // Top byte only: pins 15 and 14 move, the rest must hold
        bus_write(FUNC_SEL_HIGH_OFS, 32'h5611_1111, 4'h8);
        m_sel = {8'h56, m_sel[23:0]};
        check_route(route, exp_route(m_sel));
        // Random latch writes, clears and inverts with random lanes
        for (int i = 0; i < 40; i++)
        begin
            op = $urandom_range(2);
            v = {16'h0, 16'($urandom)};
            s4 = 4'($urandom);
            mk = 16'(lanes(s4)) & v[15:0];
            bus_write(regs[op == 0 ? 4 : op], v, s4);
            if (op == 0)
                m_level = (m_level & ~16'(lanes(s4))) | mk;
            else if (op == 1)
                m_level = m_level & ~mk;
            else
                m_level = m_level ^ mk;
            check_word({16'h0, level}, {16'h0, m_level});
            check_word({16'h0, pad_level}, {16'h0, m_level});
        end
        bus_read(BIT_CLEAR_OFS);
        check_word(d, 32'h0);
        bus_read(BIT_INVERT_OFS);
        check_word(d, 32'h0);
        // Speed fields with enables; first pass has every field full
        for (int i = 0; i < 8; i++)
        begin
            m_spd = (i == 0) ? 32'hffff_ffff : $urandom;
            bus_write(SPEED_FIELD_OFS, m_spd, 4'hf);
            m_vhs = 16'($urandom);
            bus_write(VHS_ENABLE_OFS, {16'h0, m_vhs}, 4'hf);
            check_word({16'h0, vhs}, {16'h0, exp_vhs(m_vhs, m_spd)});
        end
        bus_read(VHS_ENABLE_OFS);
        check_word(d, {16'h0, m_vhs});
        // Half-word access to the enable register is refused
        bus_write(VHS_ENABLE_OFS, 32'h0, 4'h3);
        check_word({30'h0, rsp}, {30'h0, RESP_SLVERR});
        check_word({16'h0, pad_fast}, {16'h0, exp_vhs(m_vhs, m_spd)});
        // Unmapped address: error and no side effect
        bus_write(8'h30, 32'hffff_ffff, 4'hf);
        check_word({rsp, 14'h0, level}, {RESP_SLVERR, 14'h0, m_level});
        bus_read(8'h30);
        check_word({rsp, d[29:0]}, {RESP_SLVERR, 30'h0});
        // Reset in mid-run, with select and enables no longer zero
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        check_route(route, exp_route(REG_RESET));
        check_word({level, vhs}, 32'h0);
        bus_read(FUNC_SEL_HIGH_OFS);
        check_word(d, REG_RESET);
        complete_run();
    end

    // Watchdog far above the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
